// ==== rtl/fiac_defines.vh ====
// Register offsets, field positions, reset values and timing constants
`ifndef FIAC_DEFINES_VH
`define FIAC_DEFINES_VH

// -----------------------------------------------------------------
// Special register addresses
// -----------------------------------------------------------------
`define FIAC_CMD_ADDR        8'h97
`define FIAC_UNLOCK_ADDR     8'hc9
`define FIAC_MISC2_ADDR      8'hf7
`define FIAC_LOWCFG_ADDR     8'hf6
`define FIAC_CALIB_ADDR      8'hf5

// -----------------------------------------------------------------
// Unlock codes
// -----------------------------------------------------------------
`define FIAC_CODE_REGION     8'h65
`define FIAC_CODE_FLASH_WE   8'h47
`define FIAC_CODE_EE_WE      8'he2

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define FIAC_FWE_BIT         7
`define FIAC_TO_BIT          6
`define FIAC_EWE_BIT         5
`define FIAC_UNLOCK_BIT      0
`define FIAC_LOCK_BIT        1
`define FIAC_TSEL_HI         2
`define FIAC_TSEL_LO         1
`define FIAC_MISC2_RESET     8'h06

// -----------------------------------------------------------------
// Flash and EEPROM address map
// -----------------------------------------------------------------
`define FIAC_LOCK_END        16'h01ff
`define FIAC_ALL_END         16'h3eff
`define FIAC_FREE_END        16'h3ff7
`define FIAC_CFGW_END        16'h3ffe
`define FIAC_CFG_HIGH        16'h3fff
`define FIAC_CFG_LOW         16'h3ffd
`define FIAC_CFG_CALIB       16'h3ffb
`define FIAC_EE_BASE         16'hee00
`define FIAC_EE_END          16'heefe

// -----------------------------------------------------------------
// Timing (microseconds) and derived cycle counts at 40 MHz
// -----------------------------------------------------------------
`define FIAC_CLK_MHZ         40
`define FIAC_TO1_US          900
`define FIAC_TO2_US          3600
`define FIAC_TO3_US          7200
`define FIAC_WR_US           1000
`define FIAC_TO1_CYC         (`FIAC_TO1_US * `FIAC_CLK_MHZ)
`define FIAC_TO2_CYC         (`FIAC_TO2_US * `FIAC_CLK_MHZ)
`define FIAC_TO3_CYC         (`FIAC_TO3_US * `FIAC_CLK_MHZ)
`define FIAC_WR_CYC          (`FIAC_WR_US * `FIAC_CLK_MHZ)

`endif

// ==== rtl/fiac_cfg_mem.v ====
// Config byte store for the top flash word, registered read data
`timescale 1ns/100ps
module fiac_cfg_mem #(
   parameter DEPTH = 8
) (
   input  wire       sys_clk_in,
   input  wire [2:0] wr_idx_in,
   input  wire       wr_en_in,
   input  wire [7:0] wr_data_in,
   input  wire [2:0] rd_idx_in,
   output reg  [7:0] rd_data_out
);
   reg [7:0] mem_r [0:DEPTH-1];

   always @(posedge sys_clk_in) begin
      if (wr_en_in) begin
         mem_r[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= mem_r[rd_idx_in];
   end
endmodule // fiac_cfg_mem

// ==== rtl/fiac_access_ctrl.v ====
// In-application flash and EEPROM access control
`timescale 1ns/100ps
`include "fiac_defines.vh"

// Contract
// - Flash byte write only performed while flash write enable is 1.
// - C9h gets 47h sets flash enable, E2h EEPROM enable, else clears.
// - 97h gets 65h sets region unlock, any other value clears it.
// - Bit 0 of 97h reads region unlock; it gates data-move access.
// - 0000h-01FFh: lock refuses all; else code ok, moves need unlock.
// - 0200h-3EFFh: code reads allowed; moves need region unlock.
// - 3F00h-3FF7h: code reads and moves always allowed.
// - 3FF8h-3FFEh moves need unlock; 3FFFh never by moves.
// - Lock bit is bit 1 of the high config byte at 3FFFh.
// - After reset copy low config to F6h, calibration to F5h.
// - Single byte write needs no page erase.
// - Stall CPU up to about 1 ms during a byte write.
// - Reads in 0000h-3FFEh return with no wait cycles.
// - Time-out flag C9h.6 set on time-out, cleared when C9h gets a value other than 47h or E2h.
// - Select 00 off, 01/10/11 give 0.9/3.6/7.2 ms watchdog.
// - After reset, with unlock clear, 248 bytes are writable.
// - Bit 7 of C9h reads the flash write enable flag.
// - EEPROM writes at even EE00h-EEFEh share the watchdog.
module fiac_access_ctrl #(
   parameter        WR_CYCLES = `FIAC_WR_CYC,
   parameter        TO1_CYC   = `FIAC_TO1_CYC,
   parameter        TO2_CYC   = `FIAC_TO2_CYC,
   parameter        TO3_CYC   = `FIAC_TO3_CYC
) (
   input  wire        sys_clk_in,
   input  wire        rst_in,
   input  wire [7:0]  sfr_addr_in,
   input  wire        sfr_wr_in,
   input  wire        sfr_rd_in,
   input  wire [7:0]  sfr_wdata_in,
   output reg  [7:0]  sfr_rdata_out,
   input  wire [15:0] mem_addr_in,
   input  wire        code_rd_in,
   input  wire        move_rd_in,
   input  wire        move_wr_in,
   input  wire [7:0]  move_wdata_in,
   output reg  [7:0]  mem_rdata_out,
   output reg         mem_refused_out,
   output wire        cpu_wait_out,
   output wire [15:0] nvm_addr_out,
   output wire [7:0]  nvm_wdata_out,
   input  wire [7:0]  nvm_rdata_in,
   output wire        flash_prog_out,
   output wire        ee_prog_out,
   input  wire        nvm_done_in,
   output wire        nvm_abort_out,
   output wire [7:0]  low_config_out,
   output wire [7:0]  calibration_out,
   output wire [7:0]  misc_control_two_out
);

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [2:0] ST_LOAD_HI = 3'd0;
   localparam [2:0] ST_LOAD_LO = 3'd1;
   localparam [2:0] ST_LOAD_CB = 3'd2;
   localparam [2:0] ST_IDLE    = 3'd3;
   localparam [2:0] ST_WRITE   = 3'd4;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg         flash_we_r;
   reg         ee_we_r;
   reg         timeout_r;
   reg         region_unlock_r;
   reg         lock_r;
   reg  [7:0]  low_cfg_r;
   reg  [7:0]  calib_r;
   reg  [7:0]  misc2_r;
   reg  [22:0] wdog_r;
   reg  [22:0] wr_cnt_r;
   reg  [15:0] wr_addr_r;
   reg  [7:0]  wr_data_r;
   reg         wr_is_ee_r;
   reg  [1:0]  load_wait_r;
   reg  [22:0] wdog_limit;

   wire [1:0]  tsel = misc2_r[`FIAC_TSEL_HI:`FIAC_TSEL_LO];
   wire        cfg_wr;
   wire [2:0]  cfg_rd_idx;
   wire [7:0]  cfg_rdata;

   // ------------------------------------------------------------
   // Region decode
   // ------------------------------------------------------------
   wire in_lock  = mem_addr_in <= `FIAC_LOCK_END;
   wire in_all   = !in_lock && mem_addr_in <= `FIAC_ALL_END;
   wire in_free  = mem_addr_in > `FIAC_ALL_END &&
                   mem_addr_in <= `FIAC_FREE_END;
   wire in_cfgw  = mem_addr_in > `FIAC_FREE_END &&
                   mem_addr_in <= `FIAC_CFGW_END;
   wire in_top   = mem_addr_in == `FIAC_CFG_HIGH;
   wire in_ee    = mem_addr_in >= `FIAC_EE_BASE &&
                   mem_addr_in <= `FIAC_EE_END && !mem_addr_in[0];
   wire in_flash = in_lock || in_all || in_free || in_cfgw || in_top;

   wire code_ok  = in_flash && !(in_lock && lock_r);
   wire move_ok  = (in_lock && !lock_r && region_unlock_r) ||
                   ((in_all || in_cfgw) && region_unlock_r) ||
                   in_free;

   wire idle     = state_r == ST_IDLE;
   wire wr_go    = idle && move_wr_in &&
                   ((move_ok && flash_we_r) || (in_ee && ee_we_r));

   // ------------------------------------------------------------
   // Watchdog limit select
   // ------------------------------------------------------------
   // Time-out select
   always @* begin
      case (tsel)
         2'b01:   wdog_limit = TO1_CYC[22:0];
         2'b10:   wdog_limit = TO2_CYC[22:0];
         2'b11:   wdog_limit = TO3_CYC[22:0];
         default: wdog_limit = 23'h7fffff;
      endcase
   end

   wire wdog_hit = state_r == ST_WRITE && tsel != 2'b00 &&
                   wdog_r >= wdog_limit - 23'h000001;
   // A write ends on array done or at the nominal time, whichever comes first
   wire wr_end   = nvm_done_in || wr_cnt_r >= WR_CYCLES[22:0];

   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   always @* begin
      case (state_r)
         ST_LOAD_HI: state_nxt = load_wait_r == 2'd2 ? ST_LOAD_LO : ST_LOAD_HI;
         ST_LOAD_LO: state_nxt = load_wait_r == 2'd2 ? ST_LOAD_CB : ST_LOAD_LO;
         ST_LOAD_CB: state_nxt = load_wait_r == 2'd2 ? ST_IDLE : ST_LOAD_CB;
         ST_IDLE:    state_nxt = wr_go ? ST_WRITE : ST_IDLE;
         ST_WRITE:   state_nxt = (wr_end || wdog_hit) ? ST_IDLE : ST_WRITE;
         default:    state_nxt = ST_IDLE;
      endcase
   end

   // Config bytes come from a small store; reads take one cycle
   assign cfg_rd_idx = state_r == ST_LOAD_HI ? 3'd7 :
                       state_r == ST_LOAD_LO ? 3'd5 : 3'd3;
   assign cfg_wr     = wr_go && !in_ee && mem_addr_in[15:3] == 13'h07ff;

   fiac_cfg_mem #(
      .DEPTH (8)
   ) fiac_cfg_mem_i (
      .sys_clk_in  (sys_clk_in),
      .wr_idx_in   (mem_addr_in[2:0]),
      .wr_en_in    (cfg_wr),
      .wr_data_in  (move_wdata_in),
      .rd_idx_in   (cfg_rd_idx),
      .rd_data_out (cfg_rdata)
   );

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   wire unlock_wr = sfr_wr_in && sfr_addr_in == `FIAC_UNLOCK_ADDR;
   wire cmd_wr    = sfr_wr_in && sfr_addr_in == `FIAC_CMD_ADDR;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_r         <= ST_LOAD_HI;
         flash_we_r      <= 1'b0;
         ee_we_r         <= 1'b0;
         timeout_r       <= 1'b0;
         region_unlock_r <= 1'b0;
         lock_r          <= 1'b1;
         low_cfg_r       <= 8'h00;
         calib_r         <= 8'h00;
         misc2_r         <= `FIAC_MISC2_RESET;
         wdog_r          <= 23'h000000;
         wr_cnt_r        <= 23'h000000;
         wr_addr_r       <= 16'h0000;
         wr_data_r       <= 8'h00;
         wr_is_ee_r      <= 1'b0;
         load_wait_r     <= 2'd0;
      end else begin
         state_r     <= state_nxt;
         load_wait_r <= (state_nxt != state_r) ? 2'd0 :
                        (load_wait_r == 2'd2 ? 2'd2 : load_wait_r + 2'd1);
         if (state_r == ST_LOAD_HI && load_wait_r == 2'd2) begin
            lock_r <= cfg_rdata[`FIAC_LOCK_BIT];
         end
         if (state_r == ST_LOAD_LO && load_wait_r == 2'd2) begin
            low_cfg_r <= cfg_rdata;
         end else if (sfr_wr_in && sfr_addr_in == `FIAC_LOWCFG_ADDR) begin
            low_cfg_r <= sfr_wdata_in;
         end
         if (state_r == ST_LOAD_CB && load_wait_r == 2'd2) begin
            calib_r <= cfg_rdata;
         end else if (sfr_wr_in && sfr_addr_in == `FIAC_CALIB_ADDR) begin
            calib_r <= sfr_wdata_in;
         end
         if (sfr_wr_in && sfr_addr_in == `FIAC_MISC2_ADDR) begin
            misc2_r <= sfr_wdata_in;
         end
         if (unlock_wr) begin
            flash_we_r <= sfr_wdata_in == `FIAC_CODE_FLASH_WE;
            ee_we_r    <= sfr_wdata_in == `FIAC_CODE_EE_WE;
         end
         if (cmd_wr) begin
            region_unlock_r <= sfr_wdata_in == `FIAC_CODE_REGION;
         end
         if (wdog_hit) begin
            timeout_r <= 1'b1;
         end else if (unlock_wr && sfr_wdata_in != `FIAC_CODE_FLASH_WE &&
                      sfr_wdata_in != `FIAC_CODE_EE_WE) begin
            timeout_r <= 1'b0;
         end
         if (wr_go) begin
            wr_addr_r  <= mem_addr_in;
            wr_data_r  <= move_wdata_in;
            wr_is_ee_r <= in_ee;
         end
         if (state_r == ST_WRITE) begin
            wdog_r   <= wdog_r + 23'h000001;
            wr_cnt_r <= wr_cnt_r + 23'h000001;
         end else begin
            wdog_r   <= 23'h000000;
            wr_cnt_r <= 23'h000000;
         end
      end
   end

   // ------------------------------------------------------------
   // Memory path
   // ------------------------------------------------------------
   // CPU held during write and during the config loads after reset
   assign cpu_wait_out   = state_r == ST_WRITE ||
                           (state_r < ST_IDLE);
   assign nvm_addr_out   = state_r == ST_WRITE ? wr_addr_r : mem_addr_in;
   assign nvm_wdata_out  = wr_data_r;
   assign flash_prog_out = state_r == ST_WRITE && !wr_is_ee_r;
   assign ee_prog_out    = state_r == ST_WRITE && wr_is_ee_r;
   assign nvm_abort_out  = wdog_hit;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         mem_rdata_out   <= 8'h00;
         mem_refused_out <= 1'b0;
      end else begin
         mem_refused_out <= (code_rd_in && !code_ok) ||
                            (move_rd_in && !(move_ok || in_ee)) ||
                            (move_wr_in && idle && !wr_go);
         if (code_rd_in && code_ok) begin
            mem_rdata_out <= nvm_rdata_in;
         end else if (move_rd_in && (move_ok || in_ee)) begin
            mem_rdata_out <= nvm_rdata_in;
         end else if (code_rd_in || move_rd_in) begin
            mem_rdata_out <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------
   // Register read
   // ------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         case (sfr_addr_in)
            `FIAC_CMD_ADDR:    sfr_rdata_out <= {7'h00, region_unlock_r};
            `FIAC_UNLOCK_ADDR: sfr_rdata_out <= {flash_we_r, timeout_r,
                                                 ee_we_r, 5'h00};
            `FIAC_MISC2_ADDR:  sfr_rdata_out <= misc2_r;
            `FIAC_LOWCFG_ADDR: sfr_rdata_out <= low_cfg_r;
            `FIAC_CALIB_ADDR:  sfr_rdata_out <= calib_r;
            default:           sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   assign low_config_out       = low_cfg_r;
   assign calibration_out      = calib_r;
   assign misc_control_two_out = misc2_r;

endmodule // fiac_access_ctrl

// ==== test/fiac_access_ctrl_sva.sv ====
// Assertion checker for the flash access control block
`timescale 1ns/100ps
module fiac_access_ctrl_sva #(
   parameter WR_CYCLES = 40000
) (
   input wire        sys_clk_in,
   input wire        rst_in,
   input wire [7:0]  sfr_addr_in,
   input wire        sfr_wr_in,
   input wire        sfr_rd_in,
   input wire [7:0]  sfr_wdata_in,
   input wire [7:0]  sfr_rdata_out,
   input wire [15:0] mem_addr_in,
   input wire        code_rd_in,
   input wire        move_rd_in,
   input wire        move_wr_in,
   input wire [7:0]  mem_rdata_out,
   input wire        mem_refused_out,
   input wire        cpu_wait_out,
   input wire        flash_prog_out,
   input wire        ee_prog_out,
   input wire        nvm_abort_out
);
   localparam int PROG_MAX = WR_CYCLES + 10;
   reg         fwe_r;
   reg         unl_r;
   wire        idle = !cpu_wait_out;
   wire [15:0] a    = mem_addr_in;
   // -----------------------------------------------------------
   // Shadow flags, rebuilt from register writes
   // -----------------------------------------------------------
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         fwe_r <= 1'b0;
         unl_r <= 1'b0;
      end else if (sfr_wr_in) begin
         if (sfr_addr_in == 8'hc9) fwe_r <= (sfr_wdata_in == 8'h47);
         if (sfr_addr_in == 8'h97) unl_r <= (sfr_wdata_in == 8'h65);
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   a_unlock_read:
   assert property ((sfr_wr_in && sfr_addr_in == 8'h97 &&
      sfr_wdata_in == 8'h65) ##1 (sfr_rd_in && sfr_addr_in == 8'h97)
      |=> sfr_rdata_out == 8'h01) else $error("unlock flag lost");
   a_enable_read:
   assert property ((sfr_wr_in && sfr_addr_in == 8'hc9 &&
      sfr_wdata_in == 8'h47) ##1 (sfr_rd_in && sfr_addr_in == 8'hc9)
      |=> sfr_rdata_out[7] && !sfr_rdata_out[5])
      else $error("write enable flag wrong");
   a_free_write:
   assert property (move_wr_in && idle && fwe_r && a >= 16'h3f00 &&
      a <= 16'h3ff7 |=> flash_prog_out && cpu_wait_out)
      else $error("free area write not started");
   a_enable_needed:
   assert property (move_wr_in && idle && !fwe_r && a < 16'h4000
      |=> !flash_prog_out && !cpu_wait_out && mem_refused_out)
      else $error("write ran without enable");
   a_top_refused:
   assert property (move_wr_in && idle && a == 16'h3fff
      |=> mem_refused_out && !flash_prog_out)
      else $error("top word reached by move");
   a_code_free:
   assert property (code_rd_in && idle && a >= 16'h0200 && a < 16'h4000
      |=> !mem_refused_out && !cpu_wait_out)
      else $error("code read refused or stalled");
   a_move_locked:
   assert property (move_rd_in && idle && !unl_r && ((a >= 16'h0200 &&
      a <= 16'h3eff) || (a >= 16'h3ff8 && a < 16'h4000))
      |=> mem_refused_out && mem_rdata_out == 8'h00)
      else $error("locked move read served");
   a_abort_ends:
   assert property (nvm_abort_out
      |=> !flash_prog_out && !ee_prog_out && !cpu_wait_out)
      else $error("write not abandoned");
   a_prog_bounded:
   assert property ($rose(flash_prog_out) |-> ##[1:PROG_MAX]
      !flash_prog_out) else $error("write never ended");
   cover property (nvm_abort_out);
   cover property ($fell(flash_prog_out));
   cover property ($fell(ee_prog_out));
endmodule // fiac_access_ctrl_sva

bind fiac_access_ctrl fiac_access_ctrl_sva #(.WR_CYCLES(WR_CYCLES))
   fiac_access_ctrl_sva_i (.*);

// ==== test/fiac_nvm_model.sv ====
// Behavioural flash and EEPROM array behind the access block
`timescale 1ns/100ps
module fiac_nvm_model #(
   parameter DONE_DLY = 5
) (
   input  wire        sys_clk_in,
   input  wire        rst_in,
   input  wire [15:0] nvm_addr_in,
   input  wire [7:0]  nvm_wdata_in,
   input  wire        prog_in,
   input  wire        hang_in,
   output wire [7:0]  nvm_rdata_out,
   output reg         nvm_done_out
);
   logic [7:0] mem [0:65535];
   int         cnt;
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
   end
   assign nvm_rdata_out = mem[nvm_addr_in];
   always @(posedge sys_clk_in) begin
      nvm_done_out <= 1'b0;
      if (rst_in || !prog_in || hang_in) begin
         cnt <= 0;
      end else if (cnt == DONE_DLY) begin
         cnt <= 0;
         mem[nvm_addr_in] <= nvm_wdata_in;
         nvm_done_out <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // fiac_nvm_model

// ==== test/fiac_access_ctrl_bench.sv ====
// Self-checking bench for the flash access control block
`timescale 1ns/100ps
module fiac_access_ctrl_bench;
   logic        sys_clk_in = 0, rst_in = 1, hang = 0;
   logic        sfr_wr_in = 0, sfr_rd_in = 0;
   logic        code_rd_in = 0, move_rd_in = 0, move_wr_in = 0;
   logic [7:0]  sfr_addr_in = 0, sfr_wdata_in = 0, move_wdata_in = 0;
   logic [15:0] mem_addr_in = 0;
   wire  [7:0]  sfr_rdata_out, mem_rdata_out, nvm_wdata_out, nvm_rdata_in;
   wire  [7:0]  low_config_out, calibration_out, misc_control_two_out;
   wire  [15:0] nvm_addr_out;
   wire         mem_refused_out, cpu_wait_out, flash_prog_out, ee_prog_out;
   wire         nvm_done_in, nvm_abort_out;
   int          n_mismatch = 0, checks_done = 0, cyc, lim;
   logic        rf;
   logic [15:0] ta [5] = '{16'h3eff, 16'h3f00, 16'h3ff7, 16'h3ff8, 16'h3fff};

   fiac_access_ctrl #(.WR_CYCLES(50), .TO1_CYC(10), .TO2_CYC(20),
      .TO3_CYC(30)) fiac_access_ctrl_i (.*);
   fiac_nvm_model #(.DONE_DLY(5)) fiac_nvm_model_i (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .nvm_addr_in(nvm_addr_out),
      .nvm_wdata_in(nvm_wdata_out), .prog_in(flash_prog_out | ee_prog_out),
      .hang_in(hang), .nvm_rdata_out(nvm_rdata_in),
      .nvm_done_out(nvm_done_in));

   initial begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input string nm, input logic [7:0] ex, got);
      checks_done++;
      if (got !== ex) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Resume only after hold
   // Bounded wait for the CPU hold to drop
   task automatic settle;
      cyc = 0;
      while (cpu_wait_out !== 1'b0 && cyc < 400) begin
         @(posedge sys_clk_in) #1;
         cyc++;
      end
      if (cyc == 400) begin
         n_mismatch++;
         print_verdict;
      end
   endtask
   task automatic do_reset;
      rst_in = 1;
      repeat (10) @(posedge sys_clk_in);
      #1 rst_in = 0;
      settle;
   endtask
   task automatic rd(input [7:0] a, ex);
      sfr_addr_in = a;
      sfr_rd_in = 1;
      @(posedge sys_clk_in) #1 sfr_rd_in = 0;
      chk("sfr", ex, sfr_rdata_out);
      @(posedge sys_clk_in) #1;
   endtask
   // Write then read back at once, back to back
   task automatic wr(input [7:0] a, d, ex);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1;
      @(posedge sys_clk_in) #1 sfr_wr_in = 0;
      rd(a, ex);
   endtask
   // Kind: 0 code read, 1 move read, 2 move write
   task automatic acc(input int k, input [15:0] a, input [7:0] d, input r);
      logic [7:0] pre;
      pre = fiac_nvm_model_i.mem[a];
      mem_addr_in = a;
      move_wdata_in = d;
      code_rd_in = (k == 0);
      move_rd_in = (k == 1);
      move_wr_in = (k == 2);
      @(posedge sys_clk_in) #1;
      code_rd_in = 0;
      move_rd_in = 0;
      move_wr_in = 0;
      chk("refused", {7'h0, r}, {7'h0, mem_refused_out});
      if (k < 2) chk("rdata", r ? 8'h00 : pre, mem_rdata_out);
      else chk("stall", {7'h0, !r}, {7'h0, cpu_wait_out});
      settle;
      if (k == 2 && !hang)
         chk("array", r ? pre : d, fiac_nvm_model_i.mem[a]);
      @(posedge sys_clk_in) #1;
   endtask

   initial begin
      // Config word as left by the external programmer: lock on
      fiac_access_ctrl_i.fiac_cfg_mem_i.mem_r[7] = 8'h02;
      do_reset;
      chk("misc2", 8'h06, misc_control_two_out);
      rd(8'hf7, 8'h06);
      rd(8'hc9, 8'h00);
      rd(8'h97, 8'h00);
      rd(8'h80, 8'h00);
      acc(2, 16'h3f10, 8'h33, 1);
      wr(8'hc9, 8'he2, 8'h20);
      acc(2, 16'h3f10, 8'h33, 1);
      wr(8'hc9, 8'h47, 8'h80);
      for (int u = 0; u < 2; u++) begin
         wr(8'h97, u ? 8'h65 : 8'h64, {7'h0, u[0]});
         for (int i = 0; i < 5; i++) begin
            rf = (i == 4) || (u == 0 && (i == 0 || i == 3));
            acc(2, ta[i], 8'ha0 + i[7:0], rf);
            acc(1, ta[i], 8'h00, rf);
            acc(0, ta[i], 8'h00, 0);
         end
      end
      // Lock on refuses the low region even with enable and unlock
      acc(2, 16'h0100, 8'h42, 1);
      acc(1, 16'h0100, 8'h00, 1);
      acc(0, 16'h0100, 8'h00, 1);
      // Stuck write: watchdog off first (nominal time ends it), then each select
      hang = 1;
      for (int t = 0; t < 4; t++) begin
         wr(8'hf7, {5'h0, t[1:0], 1'b0}, {5'h0, t[1:0], 1'b0});
         wr(8'hc9, 8'h47, 8'h80);
         acc(2, 16'h3f20, 8'h11, 0);
         lim = t ? 10 * t : 50;
         chk("hold", 8'h01, {7'h0, cyc + 2 >= lim && cyc <= lim + 2});
         rd(8'hc9, t ? 8'hc0 : 8'h80);
         wr(8'hc9, 8'h00, 8'h00);
      end
      hang = 0;
      wr(8'hc9, 8'he2, 8'h20);
      acc(2, 16'hee04, 8'h5c, 0);
      acc(1, 16'hee04, 8'h00, 0);
      wr(8'hc9, 8'h00, 8'h00);
      acc(2, 16'hee06, 8'h5c, 1);
      // Config bytes survive into the copies after reset
      wr(8'hc9, 8'h47, 8'h80);
      wr(8'h97, 8'h65, 8'h01);
      acc(2, 16'h3ffd, 8'ha5, 0);
      acc(2, 16'h3ffb, 8'h3c, 0);
      // Lock off for the next power-up
      fiac_access_ctrl_i.fiac_cfg_mem_i.mem_r[7] = 8'h00;
      do_reset;
      chk("lowcfg", 8'ha5, low_config_out);
      chk("calib", 8'h3c, calibration_out);
      rd(8'h97, 8'h00);
      // Enable set so only the unlock flag decides
      wr(8'hc9, 8'h47, 8'h80);
      acc(2, 16'h3eff, 8'h77, 1);
      acc(2, 16'h3f30, 8'h77, 0);
      acc(0, 16'h0100, 8'h00, 0);
      acc(1, 16'h0100, 8'h00, 1);
      wr(8'h97, 8'h65, 8'h01);
      acc(2, 16'h0100, 8'h42, 0);
      acc(1, 16'h0100, 8'h00, 0);
      print_verdict;
   end
endmodule // fiac_access_ctrl_bench
